/* File: verilog/motor_startup_option_regs.sv */
// Purpose: Start-up option register bank with decoded, latched settings
// Assumes: Register port synchronous to clk; one access per cycle
// Notes: Settings latch at start_req and hold until the next start
// Functional notes
// - Stationary window 80/160/320/640 ms from code
// - Advance angle 30 to 120 degrees
// - Speed detect only when enable bit set
// - Reverse drive only when enable bit set
// - Reverse or brake threshold 6.3 to 51 Hz
// - Open-loop current 0.2 to 1.6 A
// - Current ramp rate eight steps of VCC/s
// - Brake code zero disables brake
// - Second-order acceleration from eight codes
// - First-order acceleration from eight codes
// - Low range threshold n times 0.8 Hz
// - High range threshold (n+1) times 12.8 Hz
// - Close loop once frequency reaches threshold
`timescale 1ns/10ps
`default_nettype none
module motor_startup_option_regs #(
	parameter int TICK_DIV = startup_opt_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [startup_opt_pkg::ADDR_W-1:0] addr,
	input wire logic [startup_opt_pkg::DATA_W-1:0] wdata,
	output logic [startup_opt_pkg::DATA_W-1:0] rdata,
	output logic rvalid,
	input wire logic start_req,
	input wire logic seq_done,
	input wire logic zero_cross,
	input wire logic [11:0] motor_freq_dhz,
	output logic seq_active,
	output logic motor_stationary,
	output logic isd_run,
	output logic reverse_drive_allowed,
	output logic reverse_or_brake_go,
	output logic closed_loop,
	output logic [7:0] advance_deg,
	output logic [10:0] curr_ma,
	output logic [12:0] ramp_mvcc_s,
	output logic brake_enable,
	output logic [11:0] brake_ms,
	output logic [16:0] acc2_mhz_s2,
	output logic [16:0] acc1_mhz_s
);
	import startup_opt_pkg::*;

	// Reset asserts at once but leaves through two flops
	logic rst_s1_q, rst_n_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// Register bank
	logic [7:0] detect_q, detect_d, brake_opt_q, brake_opt_d;
	logic [7:0] accel_q, accel_d, handover_q, handover_d;
	logic [7:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	always_comb begin
		detect_d = detect_q;
		brake_opt_d = brake_opt_q;
		accel_d = accel_q;
		handover_d = handover_q;
		if (wr_en) begin
			case (addr)
				STARTUP_DETECT_OFF: detect_d = wdata;
				OL_CURRENT_BRAKE_OFF: brake_opt_d = wdata;
				STARTUP_ACCEL_OFF: accel_d = wdata;
				LOOP_HANDOVER_OFF: handover_d = wdata;
				default: ;
			endcase
		end
		// Read data holds between reads; unmapped offsets read as zero
		rvalid_d = rd_en;
		case (addr)
			STARTUP_DETECT_OFF: rdata_d = detect_q;
			OL_CURRENT_BRAKE_OFF: rdata_d = brake_opt_q;
			STARTUP_ACCEL_OFF: rdata_d = accel_q;
			LOOP_HANDOVER_OFF: rdata_d = handover_q;
			default: rdata_d = 8'h00;
		endcase
		if (!rd_en) begin
			rdata_d = rdata_q;
		end
	end
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			detect_q <= STARTUP_DETECT_RST;
			brake_opt_q <= OL_CURRENT_BRAKE_RST;
			accel_q <= STARTUP_ACCEL_RST;
			handover_q <= LOOP_HANDOVER_RST;
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			detect_q <= detect_d;
			brake_opt_q <= brake_opt_d;
			accel_q <= accel_d;
			handover_q <= handover_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// Latched copies used by the running sequence
	// Host writes during a run only take effect at the next start
	seq_state_e state_q, state_d;
	logic [7:0] lat_det_q, lat_det_d, lat_brk_q, lat_brk_d;
	logic [7:0] lat_acc_q, lat_acc_d, lat_hnd_q, lat_hnd_d;
	always_comb begin
		state_d = state_q;
		lat_det_d = lat_det_q;
		lat_brk_d = lat_brk_q;
		lat_acc_d = lat_acc_q;
		lat_hnd_d = lat_hnd_q;
		case (state_q)
			SEQ_IDLE: begin
				if (start_req) begin
					state_d = SEQ_RUN;
					lat_det_d = detect_q;
					lat_brk_d = brake_opt_q;
					lat_acc_d = accel_q;
					lat_hnd_d = handover_q;
				end
			end
			SEQ_RUN: begin
				if (seq_done) begin
					state_d = SEQ_IDLE;
				end
			end
			default: state_d = SEQ_IDLE;
		endcase
	end
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= SEQ_IDLE;
			lat_det_q <= STARTUP_DETECT_RST;
			lat_brk_q <= OL_CURRENT_BRAKE_RST;
			lat_acc_q <= STARTUP_ACCEL_RST;
			lat_hnd_q <= LOOP_HANDOVER_RST;
		end else begin
			state_q <= state_d;
			lat_det_q <= lat_det_d;
			lat_brk_q <= lat_brk_d;
			lat_acc_q <= lat_acc_d;
			lat_hnd_q <= lat_hnd_d;
		end
	end

	// Decode works on the latched copies, never the live registers
	logic [9:0] win_ms, rvs_dhz;
	logic [11:0] hnd_dhz, brk_ms_w;
	logic hnd_valid, brk_on_w;
	logic [7:0] adv_w;
	logic [10:0] curr_w;
	logic [12:0] ramp_w;
	logic [16:0] acc2_w, acc1_w;
	option_decode u_decode (
		.stat_code(lat_det_q[STAT_THR_LSB +: 2]),
		.adv_code(lat_det_q[ADV_ANGLE_LSB +: 2]),
		.rvs_code(lat_det_q[RVS_THR_LSB +: 2]),
		.curr_code(lat_brk_q[OL_CURR_LSB +: 2]),
		.ramp_code(lat_brk_q[RAMP_LSB +: 3]),
		.brake_code(lat_brk_q[BRAKE_LSB +: 3]),
		.acc2_code(lat_acc_q[ACC2_LSB +: 3]),
		.acc1_code(lat_acc_q[ACC1_LSB +: 3]),
		.handover_code(lat_hnd_q[HANDOVER_LSB +: 5]),
		.stat_window_ms(win_ms),
		.advance_deg(adv_w),
		.rvs_thr_dhz(rvs_dhz),
		.curr_ma(curr_w),
		.ramp_mvcc_s(ramp_w),
		.brake_ms(brk_ms_w),
		.brake_on(brk_on_w),
		.acc2_mhz_s2(acc2_w),
		.acc1_mhz_s(acc1_w),
		.handover_dhz(hnd_dhz),
		.handover_valid(hnd_valid)
	);

	// Free-running millisecond base shared by all windows
	logic ms_tick;
	tick_divider #(.DIV(TICK_DIV)) u_tick (
		.clk(clk),
		.rst_n(rst_n_q),
		.tick(ms_tick)
	);

	// Stationary judgment: window without a zero crossing
	// Tick phase is free, so the first counted ms may be short
	logic [9:0] quiet_ms_q, quiet_ms_d;
	logic run;
	logic active_d, active_q;
	logic stat_d, stat_q;
	logic isd_d, isd_q;
	logic rvs_d, rvs_q;
	logic go_d, go_q;
	logic closed_d, closed_q;
	logic brk_en_d, brk_en_q;

	// Both frequency thresholds use the same inclusive compare
	function automatic logic freq_reached(input logic [11:0] freq, input logic [11:0] thr);
		return freq >= thr;
	endfunction

	always_comb begin
		run = (state_q == SEQ_RUN);
		quiet_ms_d = quiet_ms_q;
		if (!run || zero_cross) begin
			quiet_ms_d = 10'h000;
		end else if (ms_tick && quiet_ms_q != win_ms) begin
			quiet_ms_d = quiet_ms_q + 10'h001;
		end
		active_d = run;
		stat_d = run && lat_det_q[ISD_EN_BIT] && !zero_cross
			&& (quiet_ms_q == win_ms);
		isd_d = run && lat_det_q[ISD_EN_BIT];
		rvs_d = run && lat_det_q[RVS_EN_BIT];
		go_d = run && (lat_det_q[RVS_EN_BIT] || brk_on_w)
			&& freq_reached(motor_freq_dhz, 12'(rvs_dhz));
		// Invalid code 00000 never closes the loop
		closed_d = run && hnd_valid && freq_reached(motor_freq_dhz, hnd_dhz);
		// Reflects the latched code in idle as well
		brk_en_d = brk_on_w;
	end
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			quiet_ms_q <= 10'h000;
			active_q <= 1'b0;
			stat_q <= 1'b0;
			isd_q <= 1'b0;
			rvs_q <= 1'b0;
			go_q <= 1'b0;
			closed_q <= 1'b0;
			brk_en_q <= 1'b0;
		end else begin
			quiet_ms_q <= quiet_ms_d;
			active_q <= active_d;
			stat_q <= stat_d;
			isd_q <= isd_d;
			rvs_q <= rvs_d;
			go_q <= go_d;
			closed_q <= closed_d;
			brk_en_q <= brk_en_d;
		end
	end

	// Decoded settings registered so outputs come from flops
	// One flop after decode keeps the wide table outputs glitch-free
	logic [7:0] adv_q, adv_d;
	logic [10:0] curr_q, curr_d;
	logic [12:0] ramp_q, ramp_d;
	logic [11:0] brk_ms_q, brk_ms_d;
	logic [16:0] acc2_q, acc2_d;
	logic [16:0] acc1_q, acc1_d;
	always_comb begin
		adv_d = adv_w;
		curr_d = curr_w;
		ramp_d = ramp_w;
		brk_ms_d = brk_ms_w;
		acc2_d = acc2_w;
		acc1_d = acc1_w;
	end
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			adv_q <= 8'h00;
			curr_q <= 11'h000;
			ramp_q <= 13'h0000;
			brk_ms_q <= 12'h000;
			acc2_q <= 17'h00000;
			acc1_q <= 17'h00000;
		end else begin
			adv_q <= adv_d;
			curr_q <= curr_d;
			ramp_q <= ramp_d;
			brk_ms_q <= brk_ms_d;
			acc2_q <= acc2_d;
			acc1_q <= acc1_d;
		end
	end

	assign rdata = rdata_q;
	assign rvalid = rvalid_q;
	assign seq_active = active_q;
	assign motor_stationary = stat_q;
	assign isd_run = isd_q;
	assign reverse_drive_allowed = rvs_q;
	assign reverse_or_brake_go = go_q;
	assign closed_loop = closed_q;
	assign brake_enable = brk_en_q;
	assign advance_deg = adv_q;
	assign curr_ma = curr_q;
	assign ramp_mvcc_s = ramp_q;
	assign brake_ms = brk_ms_q;
	assign acc2_mhz_s2 = acc2_q;
	assign acc1_mhz_s = acc1_q;
endmodule
`default_nettype wire

/* File: verilog/startup_opt_pkg.sv */
// Purpose: Shared constants for the motor start-up option register bank
// Assumes: 8-bit registers at byte offsets 0x23..0x26
// Notes: Decoded settings use fixed-point units listed beside each table
package startup_opt_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] STARTUP_DETECT_OFF = 8'h23;
	localparam logic [7:0] OL_CURRENT_BRAKE_OFF = 8'h24;
	localparam logic [7:0] STARTUP_ACCEL_OFF = 8'h25;
	localparam logic [7:0] LOOP_HANDOVER_OFF = 8'h26;
	localparam logic [7:0] STARTUP_DETECT_RST = 8'h00;
	localparam logic [7:0] OL_CURRENT_BRAKE_RST = 8'h00;
	localparam logic [7:0] STARTUP_ACCEL_RST = 8'h00;
	localparam logic [7:0] LOOP_HANDOVER_RST = 8'h08;
	// Field positions
	localparam int STAT_THR_LSB = 6;
	localparam int ADV_ANGLE_LSB = 4;
	localparam int ISD_EN_BIT = 3;
	localparam int RVS_EN_BIT = 2;
	localparam int RVS_THR_LSB = 0;
	localparam int OL_CURR_LSB = 6;
	localparam int RAMP_LSB = 3;
	localparam int BRAKE_LSB = 0;
	localparam int ACC2_LSB = 3;
	localparam int ACC1_LSB = 0;
	localparam int HANDOVER_LSB = 3;
	// Clock and timing
	localparam int CLK_HZ = 40_000_000;
	localparam int MS_PER_TICK = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * MS_PER_TICK;
	localparam int STAT_BASE_MS = 80;
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_RUN = 2'b01
	} seq_state_e;
endpackage

/* File: verilog/option_decode.sv */
// Purpose: Map start-up option codes to physical settings
// Assumes: Fields held stable by the caller
// Notes: Units are mA, mVCC/s, ms, mHz/s, mHz/s^2, Hz/10 and degrees
`timescale 1ns/10ps
`default_nettype none
module option_decode (
	input wire logic [1:0] stat_code,
	input wire logic [1:0] adv_code,
	input wire logic [1:0] rvs_code,
	input wire logic [1:0] curr_code,
	input wire logic [2:0] ramp_code,
	input wire logic [2:0] brake_code,
	input wire logic [2:0] acc2_code,
	input wire logic [2:0] acc1_code,
	input wire logic [4:0] handover_code,
	output logic [9:0] stat_window_ms,
	output logic [7:0] advance_deg,
	output logic [9:0] rvs_thr_dhz,
	output logic [10:0] curr_ma,
	output logic [12:0] ramp_mvcc_s,
	output logic [11:0] brake_ms,
	output logic brake_on,
	output logic [16:0] acc2_mhz_s2,
	output logic [16:0] acc1_mhz_s,
	output logic [11:0] handover_dhz,
	output logic handover_valid
);
	import startup_opt_pkg::*;
	always_comb begin
		stat_window_ms = 10'(STAT_BASE_MS << stat_code);
		advance_deg = 8'(30 * (adv_code + 1));
		curr_ma = 11'(200 << curr_code);
		case (rvs_code)
			2'h0: rvs_thr_dhz = 10'd63;
			2'h1: rvs_thr_dhz = 10'd130;
			2'h2: rvs_thr_dhz = 10'd260;
			default: rvs_thr_dhz = 10'd510;
		endcase
		case (ramp_code)
			3'h0: ramp_mvcc_s = 13'd6000;
			3'h1: ramp_mvcc_s = 13'd3000;
			3'h2: ramp_mvcc_s = 13'd1500;
			3'h3: ramp_mvcc_s = 13'd700;
			3'h4: ramp_mvcc_s = 13'd340;
			3'h5: ramp_mvcc_s = 13'd160;
			3'h6: ramp_mvcc_s = 13'd70;
			default: ramp_mvcc_s = 13'd23;
		endcase
		brake_on = (brake_code != 3'h0);
		case (brake_code)
			3'h1: brake_ms = 12'd2700;
			3'h2: brake_ms = 12'd1300;
			3'h3: brake_ms = 12'd670;
			3'h4: brake_ms = 12'd330;
			3'h5: brake_ms = 12'd160;
			3'h6: brake_ms = 12'd80;
			3'h7: brake_ms = 12'd40;
			default: brake_ms = 12'd0;
		endcase
		case (acc2_code)
			3'h0: acc2_mhz_s2 = 17'd57000;
			3'h1: acc2_mhz_s2 = 17'd29000;
			3'h2: acc2_mhz_s2 = 17'd14000;
			3'h3: acc2_mhz_s2 = 17'd6900;
			3'h4: acc2_mhz_s2 = 17'd3300;
			3'h5: acc2_mhz_s2 = 17'd1600;
			3'h6: acc2_mhz_s2 = 17'd660;
			default: acc2_mhz_s2 = 17'd220;
		endcase
		case (acc1_code)
			3'h0: acc1_mhz_s = 17'd76000;
			3'h1: acc1_mhz_s = 17'd38000;
			3'h2: acc1_mhz_s = 17'd19000;
			3'h3: acc1_mhz_s = 17'd9200;
			3'h4: acc1_mhz_s = 17'd4500;
			3'h5: acc1_mhz_s = 17'd2100;
			3'h6: acc1_mhz_s = 17'd900;
			default: acc1_mhz_s = 17'd300;
		endcase
		if (handover_code[4]) begin
			handover_dhz = 12'(128 * (handover_code[3:0] + 1));
			handover_valid = 1'b1;
		end else begin
			handover_dhz = 12'(8 * handover_code[3:0]);
			handover_valid = (handover_code[3:0] != 4'h0);
		end
	end
endmodule
`default_nettype wire

/* File: verilog/tick_divider.sv */
// Purpose: One-cycle enable pulse every DIV clocks
// Assumes: DIV at least 1
// Notes: Used as the millisecond time base
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
	parameter int DIV = 40000
) (
	input wire logic clk,
	input wire logic rst_n,
	output logic tick
);
	logic [31:0] cnt_q, cnt_d;
	logic tick_d, tick_q;
	always_comb begin
		tick_d = (cnt_q == 32'(DIV - 1));
		cnt_d = tick_d ? 32'h0 : cnt_q + 32'h1;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 32'h0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end
	assign tick = tick_q;
endmodule
`default_nettype wire

/* File: bench/startup_opt_asserts.sv */
// Purpose: Port checks for the start-up option bank
// Assumes: Sees top ports only
// Notes: Settings move with seq_active, so depth 2 skips the start edge
`timescale 1ns/10ps
`default_nettype none
module startup_opt_asserts (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic rd_en,
	input wire logic rvalid,
	input wire logic zero_cross,
	input wire logic seq_active,
	input wire logic motor_stationary,
	input wire logic isd_run,
	input wire logic reverse_drive_allowed,
	input wire logic closed_loop,
	input wire logic brake_enable,
	input wire logic [11:0] brake_ms,
	input wire logic [7:0] advance_deg,
	input wire logic [10:0] curr_ma
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_rv; rvalid == $past(rd_en); endproperty
	a_rv: assert property (p_rv) else $error("rvalid wrong");
	property p_brk; brake_enable == (brake_ms != 12'h000); endproperty
	a_brk: assert property (p_brk) else $error("brake flag wrong");
	property p_isd; isd_run |-> seq_active; endproperty
	a_isd: assert property (p_isd) else $error("detect outside run");
	property p_rvs; reverse_drive_allowed |-> seq_active; endproperty
	a_rvs: assert property (p_rvs) else $error("reverse outside run");
	property p_stat; zero_cross |-> ##2 !motor_stationary; endproperty
	a_stat: assert property (p_stat) else $error("stationary after crossing");
	property p_cl; closed_loop |-> seq_active; endproperty
	a_cl: assert property (p_cl) else $error("closed loop outside run");
	property p_hold; seq_active && $past(seq_active, 2) |-> $stable(advance_deg) && $stable(curr_ma); endproperty
	a_hold: assert property (p_hold) else $error("setting moved in run");
	property p_curr; seq_active |-> curr_ma inside {200, 400, 800, 1600}; endproperty
	a_curr: assert property (p_curr) else $error("current level wrong");
endmodule
bind motor_startup_option_regs startup_opt_asserts startup_opt_asserts_i (
	.clk(clk),
	.arst_n(arst_n),
	.rd_en(rd_en),
	.rvalid(rvalid),
	.zero_cross(zero_cross),
	.seq_active(seq_active),
	.motor_stationary(motor_stationary),
	.isd_run(isd_run),
	.reverse_drive_allowed(reverse_drive_allowed),
	.closed_loop(closed_loop),
	.brake_enable(brake_enable),
	.brake_ms(brake_ms),
	.advance_deg(advance_deg),
	.curr_ma(curr_ma)
);
`default_nettype wire

/* File: bench/host_model.sv */
// Purpose: Host side of the register port
// Assumes: Strobes change on the falling edge
// Notes: Write data inverted once released
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input wire logic clk,
	output logic wr_en,
	output logic rd_en,
	output logic [7:0] addr,
	output logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		wr_en = 1'b1;
		addr = a;
		wdata = v;
		@(negedge clk);
		wr_en = 1'b0;
		wdata = ~v;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge clk);
		rd_en = 1'b1;
		addr = a;
		@(negedge clk);
		rd_en = 1'b0;
		// Taken while rvalid stands, half a cycle after the rising edge that registers the read
		v = rdata;
	endtask
endmodule
`default_nettype wire

/* File: bench/tb_motor_startup_option_regs.sv */
// Purpose: Self-checking bench for the start-up option bank
// Assumes: TICK_DIV of 4 shortens the millisecond base
// Notes: Stationary edge checked with a margin for tick phase
`timescale 1ns/10ps
`default_nettype none
module tb_motor_startup_option_regs;
	import startup_opt_pkg::*;
	logic clk, arst_n, wr_en, rd_en, rvalid, start_req, seq_done, zero_cross, seq_active;
	logic motor_stationary, isd_run, reverse_drive_allowed, reverse_or_brake_go;
	logic closed_loop, brake_enable;
	logic [7:0] addr, wdata, rdata, advance_deg, d;
	logic [11:0] motor_freq_dhz, brake_ms;
	logic [10:0] curr_ma;
	logic [12:0] ramp_mvcc_s;
	logic [16:0] acc2_mhz_s2, acc1_mhz_s;
	logic [7:0] r[4];
	logic [7:0] rv[6] = '{8'h00, STARTUP_DETECT_RST, OL_CURRENT_BRAKE_RST, STARTUP_ACCEL_RST,
		LOOP_HANDOVER_RST, 8'h00};
	int error_cnt, n_checks, w, ht, rt, f;
	int rmp[8] = '{6000, 3000, 1500, 700, 340, 160, 70, 23};
	int brk[8] = '{0, 2700, 1300, 670, 330, 160, 80, 40};
	int a2[8] = '{57000, 29000, 14000, 6900, 3300, 1600, 660, 220};
	int a1[8] = '{76000, 38000, 19000, 9200, 4500, 2100, 900, 300};
	int rth[4] = '{63, 130, 260, 510};
	motor_startup_option_regs #(.TICK_DIV(4)) motor_startup_option_regs_i (
		.clk(clk),
		.arst_n(arst_n),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.addr(addr),
		.wdata(wdata),
		.rdata(rdata),
		.rvalid(rvalid),
		.start_req(start_req),
		.seq_done(seq_done),
		.zero_cross(zero_cross),
		.motor_freq_dhz(motor_freq_dhz),
		.seq_active(seq_active),
		.motor_stationary(motor_stationary),
		.isd_run(isd_run),
		.reverse_drive_allowed(reverse_drive_allowed),
		.reverse_or_brake_go(reverse_or_brake_go),
		.closed_loop(closed_loop),
		.advance_deg(advance_deg),
		.curr_ma(curr_ma),
		.ramp_mvcc_s(ramp_mvcc_s),
		.brake_enable(brake_enable),
		.brake_ms(brake_ms),
		.acc2_mhz_s2(acc2_mhz_s2),
		.acc1_mhz_s(acc1_mhz_s)
	);
	host_model host_model_i (
		.clk(clk),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.addr(addr),
		.wdata(wdata),
		.rdata(rdata)
	);
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s expected %0h seen %0h", n, e, s);
		end
	endtask
	task automatic test_done();
		if (error_cnt == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic cfg();
		chk("angle", advance_deg, 30 * (r[0][5:4] + 1));
		chk("isd", isd_run, r[0][3]);
		chk("rvs", reverse_drive_allowed, r[0][2]);
		chk("curr", curr_ma, 200 << r[1][7:6]);
		chk("ramp", ramp_mvcc_s, rmp[r[1][5:3]]);
		chk("brake", brake_ms, brk[r[1][2:0]]);
		chk("brake_en", brake_enable, r[1][2:0] != 3'h0);
		chk("acc2", acc2_mhz_s2, a2[r[2][5:3]]);
		chk("acc1", acc1_mhz_s, a1[r[2][2:0]]);
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#2000000;
		error_cnt++;
		test_done();
	end
	initial begin
		arst_n = 1'b0;
		start_req = 1'b0;
		seq_done = 1'b0;
		zero_cross = 1'b0;
		motor_freq_dhz = 12'h000;
		void'($urandom(32'h9A04));
		repeat (10) @(negedge clk);
		arst_n = 1'b1;
		repeat (3) @(negedge clk);
		for (int i = 0; i < 6; i++) begin
			host_model_i.rd(8'(8'h22 + i), d);
			chk("rvalid", rvalid, 1'b1);
			chk("reset", d, rv[i]);
		end
		for (int k = 0; k < 8; k++) begin
			for (int i = 0; i < 4; i++) begin
				r[i] = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
				host_model_i.wr(8'(8'h23 + i), r[i]);
			end
			host_model_i.wr(8'h27, 8'($urandom));
			for (int i = 0; i < 6; i++) begin
				host_model_i.rd(8'(8'h22 + i), d);
				chk("rvalid", rvalid, 1'b1);
				chk("reg", d, (i == 0 || i == 5) ? 8'h00 : r[i - 1]);
			end
			@(negedge clk);
			start_req = 1'b1;
			@(negedge clk);
			start_req = 1'b0;
			repeat (4) @(negedge clk);
			chk("active", seq_active, 1'b1);
			cfg();
			w = (80 << r[0][7:6]) * 4;
			repeat (w - 30) @(negedge clk);
			chk("still", motor_stationary, 1'b0);
			repeat (40) @(negedge clk);
			chk("still", motor_stationary, r[0][3]);
			zero_cross = 1'b1;
			@(negedge clk);
			zero_cross = 1'b0;
			repeat (3) @(negedge clk);
			chk("moving", motor_stationary, 1'b0);
			ht = r[3][7] ? (r[3][6:3] + 1) * 128 : r[3][6:3] * 8;
			rt = rth[r[0][1:0]];
			for (int j = 0; j < 4; j++) begin
				f = (j < 2 ? ht : rt) - 1 + j % 2;
				// A zero threshold would otherwise wrap to full scale
				if (f < 0) begin
					f = 0;
				end
				motor_freq_dhz = 12'(f);
				repeat (4) @(negedge clk);
				chk("closed", closed_loop, r[3][7:3] != 5'h00 && f >= 0 && f >= ht);
				chk("go", reverse_or_brake_go, (r[0][2] || r[1][2:0] != 3'h0) && f >= rt);
			end
			for (int i = 0; i < 4; i++) begin
				host_model_i.wr(8'(8'h23 + i), ~r[i]);
			end
			repeat (4) @(negedge clk);
			cfg();
			seq_done = 1'b1;
			@(negedge clk);
			seq_done = 1'b0;
			motor_freq_dhz = 12'h000;
			repeat (4) @(negedge clk);
			chk("idle", seq_active, 1'b0);
			chk("isd_idle", isd_run, 1'b0);
			chk("rvs_idle", reverse_drive_allowed, 1'b0);
			chk("closed_idle", closed_loop, 1'b0);
			chk("still_idle", motor_stationary, 1'b0);
		end
		test_done();
	end
endmodule
`default_nettype wire
